// ==== hw/pbc_ctrl_reg.sv ====
// basic phy control register, reached through management frame accesses
// Behaviour
// - register is read and written only via management frame accesses.
// - writing 1 to bit 15 resets all registers; bit clears itself.
// - bit 15 reads 1 during soft reset; accesses refused until done.
// - bit 14 loops transmit nibbles to receive, receiver cut off.
// - loopback entry may give up to 560 ns receive dead time.
// - hardware loopback strap overrides the register loopback bit.
// - bit 13 selects 100 or 10 Mbps when autoneg off; resets 1.
// - bit 12 enables autoneg, default 1; manual speed/duplex ignored then.
// - bit 11 places the device in low-power mode.
// - bit 11 ORed with link power-down request.
// - bit 10 isolates internal medium-independent interface both directions.
// - writing 1 to bit 9 restarts autoneg; bit self clears.
// - bit 8 selects duplex when autoneg off; default half.
// - with autoneg on, bit 8 reads 1 and ignores writes.
// - in loopback, behaviour ignores duplex bit.
// - bit 7 collision test has no effect, writable, default 1.
`timescale 1ns/1ps
module pbc_ctrl_reg
	import pbc_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// management access from the host side link
	input wire logic mgmt_valid,
	input wire logic mgmt_write,
	input wire logic [4:0] mgmt_addr,
	input wire logic [15:0] mgmt_wdata,
	output logic mgmt_ready,
	output logic [15:0] mgmt_rdata,
	output logic mgmt_rvalid,
	// hardware straps and link requests
	input wire logic strap_loopback,
	input wire logic link_power_down,
	// controls to the phy core
	output logic soft_reset,
	output logic loopback_en,
	output logic rx_dead_window,
	output logic speed_100,
	output logic full_duplex,
	output logic autoneg_en,
	output logic autoneg_restart,
	output logic power_down,
	output logic mii_isolate
);
	pbc_state_e state;
	pbc_state_e next_state;
	logic [15:0] ctrl;
	logic [15:0] next_ctrl;
	logic [15:0] rdata;
	logic [15:0] next_rdata;
	logic rvalid;
	logic next_rvalid;
	logic anrst_start;
	logic anrst_busy;
	logic srst_busy;
	logic srst_start;
	logic loop_q;
	logic next_loop_q;
	logic srst_done;
	logic rd_hit;
	logic dead_start;
	logic wr_hit;
	logic [15:0] readback;

	assign wr_hit = mgmt_valid && mgmt_ready && mgmt_write && (mgmt_addr == PBC_ADDR_CTRL);
	assign srst_start = wr_hit && mgmt_wdata[PBC_BIT_RESET];
	assign anrst_start = wr_hit && mgmt_wdata[PBC_BIT_ANRST] && !mgmt_wdata[PBC_BIT_RESET];
	assign rd_hit = mgmt_valid && mgmt_ready && !mgmt_write;
	// soft reset ends once its timer has run out
	assign srst_done = (state == PBC_SRST) && !srst_busy;

	// soft reset duration
	pbc_pulse_timer #(.W(8)) u_srst (
		.clk(clk),
		.nrst(nrst),
		.start(srst_start),
		.length(8'(PBC_SRST_CYCLES)),
		.busy(srst_busy)
	);

	// restart pulse, two cycles long
	pbc_pulse_timer #(.W(8)) u_anrst (
		.clk(clk),
		.nrst(nrst),
		.start(anrst_start),
		.length(8'(PBC_ANRST_CYCLES)),
		.busy(anrst_busy)
	);

	// receive dead window after loopback entry
	pbc_pulse_timer #(.W(8)) u_dead (
		.clk(clk),
		.nrst(nrst),
		.start(dead_start),
		.length(8'(PBC_DEAD_CYCLES)),
		.busy(rx_dead_window)
	);

	// soft reset runs until its timer has expired
	always_comb begin
		next_state = state;
		case (state)
			PBC_IDLE: begin
				if (srst_start) begin
					next_state = PBC_SRST;
				end
			end
			PBC_SRST: begin
				if (!srst_busy) begin
					next_state = PBC_IDLE;
				end
			end
			default: begin
				next_state = PBC_IDLE;
			end
		endcase
	end

	// refuse accesses while the soft reset runs
	assign mgmt_ready = (state == PBC_IDLE);

	// readback: self-clearing bits and the forced duplex bit
	always_comb begin
		readback = ctrl & PBC_CTRL_WMASK;
		readback[PBC_BIT_RESET] = (state == PBC_SRST);
		readback[PBC_BIT_ANRST] = 1'b0;
		if (ctrl[PBC_BIT_ANEN]) begin
			readback[PBC_BIT_DUPLEX] = 1'b1;
		end
	end

	// control word: a finishing soft reset wins over any write
	always_comb begin
		next_ctrl = ctrl;
		if (srst_done) begin
			next_ctrl = PBC_CTRL_RESET;
		end else if (wr_hit && !srst_start) begin
			next_ctrl = mgmt_wdata & PBC_CTRL_WMASK;
			// reserved bits stored as written; host keeps them zero
			next_ctrl[6:0] = mgmt_wdata[6:0];
			if (ctrl[PBC_BIT_ANEN]) begin
				next_ctrl[PBC_BIT_DUPLEX] = ctrl[PBC_BIT_DUPLEX];
			end
		end
	end

	// read answer: valid for one cycle, data held until the next read
	always_comb begin
		next_rdata = rdata;
		next_rvalid = 1'b0;
		if (rd_hit) begin
			next_rvalid = 1'b1;
			// other registers live outside this block and read as zero
			next_rdata = (mgmt_addr == PBC_ADDR_CTRL) ? readback : 16'h0000;
		end
	end

	// previous loopback level; zero after reset matches the idle level
	always_comb begin
		next_loop_q = loopback_en;
	end

	// state register
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state <= PBC_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// hardware reset loads the same defaults a soft reset restores
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl <= PBC_CTRL_RESET;
		end else begin
			ctrl <= next_ctrl;
		end
	end

	// read word and its valid pulse
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdata <= 16'h0000;
			rvalid <= 1'b0;
		end else begin
			rdata <= next_rdata;
			rvalid <= next_rvalid;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			loop_q <= 1'b0;
		end else begin
			loop_q <= next_loop_q;
		end
	end

	assign mgmt_rdata = rdata;
	assign mgmt_rvalid = rvalid;
	assign soft_reset = (state == PBC_SRST);
	// strap wins over the register bit whenever it is asserted
	assign loopback_en = strap_loopback | ctrl[PBC_BIT_LOOP];
	// receive path flagged as possibly dead after loopback entry
	assign dead_start = loopback_en && !loop_q;
	assign autoneg_en = ctrl[PBC_BIT_ANEN];
	assign speed_100 = ctrl[PBC_BIT_ANEN] ? 1'b1 : ctrl[PBC_BIT_SPEED];
	// duplex ignored in loopback and under autoneg
	assign full_duplex = (ctrl[PBC_BIT_ANEN] || loopback_en) ? 1'b1
		: ctrl[PBC_BIT_DUPLEX];
	assign autoneg_restart = anrst_busy;
	assign power_down = ctrl[PBC_BIT_PDOWN] | link_power_down;
	assign mii_isolate = ctrl[PBC_BIT_ISOL];
	// collision test bit is stored only and drives nothing
endmodule // pbc_ctrl_reg

// ==== include/pbc_pkg.sv ====
// constants for the basic phy control register bank
package pbc_pkg;
	localparam logic [4:0] PBC_ADDR_CTRL = 5'h00;
	localparam int PBC_BIT_RESET = 15;
	localparam int PBC_BIT_LOOP = 14;
	localparam int PBC_BIT_SPEED = 13;
	localparam int PBC_BIT_ANEN = 12;
	localparam int PBC_BIT_PDOWN = 11;
	localparam int PBC_BIT_ISOL = 10;
	localparam int PBC_BIT_ANRST = 9;
	localparam int PBC_BIT_DUPLEX = 8;
	localparam int PBC_BIT_COLT = 7;
	localparam logic [15:0] PBC_CTRL_RESET = 16'h3080;
	// writable bits held in storage; 15 and 9 are self clearing and not stored
	localparam logic [15:0] PBC_CTRL_WMASK = 16'h7dff;
	// soft reset duration in cycles of the management clock
	localparam int PBC_SRST_CYCLES = 16;
	localparam int PBC_ANRST_CYCLES = 2;
	// descrambler dead time after loopback entry
	localparam int PBC_DEAD_NS = 560;
	localparam int PBC_CLK_NS = 4;
	localparam int PBC_DEAD_CYCLES = PBC_DEAD_NS / PBC_CLK_NS;
	typedef enum logic [1:0] {
		PBC_IDLE = 2'b00,
		PBC_SRST = 2'b01
	} pbc_state_e;
endpackage

// ==== hw/pbc_pulse_timer.sv ====
// down counter that holds busy for a programmed number of cycles
`timescale 1ns/1ps
module pbc_pulse_timer #(
	parameter int W = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// control
	input wire logic start,
	input wire logic [W-1:0] length,
	output logic busy
);
	logic [W-1:0] cnt;
	logic [W-1:0] next_cnt;

	always_comb begin
		next_cnt = cnt;
		if (start) begin
			next_cnt = length;
		end else if (cnt != '0) begin
			next_cnt = cnt - 1'b1;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt <= '0;
		end else begin
			cnt <= next_cnt;
		end
	end

	assign busy = (cnt != '0);
endmodule // pbc_pulse_timer

// ==== tb/pbc_host_model.sv ====
// mac side master issuing management accesses
`timescale 1ns/1ps
module pbc_host_model (
	// clock and answer
	input wire logic clk, mgmt_ready, mgmt_rvalid,
	input wire logic [15:0] mgmt_rdata,
	// request
	output logic mgmt_valid, mgmt_write,
	output logic [4:0] mgmt_addr,
	output logic [15:0] mgmt_wdata
);
	initial {mgmt_valid, mgmt_write, mgmt_addr, mgmt_wdata} = '0;
	// ok stays low when the request is never taken
	task automatic access(input logic w, input logic [4:0] a, input logic [15:0] d,
			output logic [15:0] q, output bit ok);
		ok = 0;
		#1 {mgmt_valid, mgmt_write, mgmt_addr, mgmt_wdata} = {1'b1, w, a, d};
		for (int i = 0; i < 40 && !ok; i++) begin
			@(posedge clk);
			ok = mgmt_ready;
		end
		#1 {mgmt_valid, mgmt_addr, mgmt_wdata} = {1'b0, ~a, ~d};
		@(posedge clk);
		q = mgmt_rdata;
		if (!w && !mgmt_rvalid) ok = 0;
	endtask
endmodule // pbc_host_model

// ==== tb/pbc_ctrl_reg_properties.sv ====
// port assertions for the control register
`timescale 1ns/1ps
module pbc_ctrl_reg_chk (
	input wire logic clk, nrst, mgmt_valid, mgmt_write, mgmt_ready, mgmt_rvalid,
	input wire logic strap_loopback, link_power_down, soft_reset, loopback_en,
	input wire logic rx_dead_window, full_duplex, autoneg_en, autoneg_restart,
	input wire logic power_down,
	input wire logic [4:0] mgmt_addr,
	input wire logic [15:0] mgmt_wdata
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	wire logic wr0 = mgmt_valid && mgmt_ready && mgmt_write && mgmt_addr == 5'h00;
	wire logic rd = mgmt_valid && mgmt_ready && !mgmt_write;
	busy_ready_a: assert property (soft_reset |-> !mgmt_ready) else $error("busy");
	srst_go_a: assert property (wr0 && mgmt_wdata[15] |=> soft_reset) else $error("go");
	srst_end_a: assert property ($rose(soft_reset) |-> soft_reset[*8] ##[1:20] !soft_reset)
		else $error("reset length");
	strap_loop_a: assert property (strap_loopback |-> loopback_en) else $error("strap");
	pdown_or_a: assert property (link_power_down |-> power_down) else $error("pdown");
	an_duplex_a: assert property (autoneg_en || loopback_en |-> full_duplex)
		else $error("duplex");
	read_ans_a: assert property (rd |=> mgmt_rvalid) else $error("no answer");
	rvalid_cause_a: assert property (mgmt_rvalid |-> $past(rd)) else $error("stray");
	an_restart_a: assert property (wr0 && mgmt_wdata[9] && !mgmt_wdata[15]
		|=> autoneg_restart[*2] ##1 !autoneg_restart) else $error("restart");
	dead_time_a: assert property ($rose(loopback_en) |=> rx_dead_window)
		else $error("dead");
	cover property (rd);
	cover property ($rose(soft_reset));
	cover property ($rose(rx_dead_window));
endmodule // pbc_ctrl_reg_chk
bind pbc_ctrl_reg pbc_ctrl_reg_chk pbc_ctrl_reg_chk_i (.*);

// ==== tb/pbc_ctrl_reg_tb.sv ====
// self-checking bench for the control register
`timescale 1ns/1ps
module pbc_ctrl_reg_tb;
	logic clk = 0, nrst = 0, strap_loopback = 0, link_power_down = 0;
	logic mgmt_valid, mgmt_write, mgmt_ready, mgmt_rvalid, soft_reset, loopback_en;
	logic rx_dead_window, speed_100, full_duplex, autoneg_en, autoneg_restart;
	logic power_down, mii_isolate;
	logic [4:0] mgmt_addr;
	logic [15:0] mgmt_wdata, mgmt_rdata, q;
	int n_mismatch = 0, n_compared = 0;
	wire logic [15:0] fl = {9'h0, rx_dead_window, speed_100, full_duplex, autoneg_en,
		loopback_en, power_down, mii_isolate};
	always #2 clk = ~clk;
	pbc_ctrl_reg pbc_ctrl_reg_i (.*);
	pbc_host_model pbc_host_model_i (.*);
	task automatic conclude;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] g, e);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %0t got %h want %h", $time, g, e);
		end
	endtask
	// write effects land at the taking edge; outputs are looked at one cycle later
	task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d);
		bit ok;
		pbc_host_model_i.access(w, a, d, q, ok);
		// look at the outputs once the edge after the taking edge has settled them
		#1;
		if (!ok) begin
			n_mismatch++;
			$display("CHECK FAILED %0t access not answered", $time);
			conclude;
		end
	endtask
	task automatic t_dflt;
		acc(0, 5'h00, 16'h0);
		chk(q, 16'h3180);
		chk(fl, 16'h0038);
		acc(0, 5'h01, 16'h0);
		chk(q, 16'h0000);
		acc(1, 5'h01, 16'h0000);
		acc(0, 5'h00, 16'h0);
		chk(q, 16'h3180);
		$display("defaults done");
	endtask
	task automatic t_manual;
		acc(1, 5'h00, 16'h0100);
		chk(fl, 16'h0000);
		acc(1, 5'h00, 16'h0100);
		chk(fl, 16'h0010);
		acc(1, 5'h00, 16'h2000);
		chk(fl, 16'h0020);
		acc(1, 5'h00, 16'h1000);
		chk(fl, 16'h0038);
		acc(0, 5'h00, 16'h0);
		chk(q, 16'h1100);
		$display("manual done");
	endtask
	task automatic t_bits;
		acc(1, 5'h00, 16'h4c80);
		chk(fl, 16'h0057);
		acc(0, 5'h00, 16'h0);
		chk(q, 16'h4c80);
		acc(1, 5'h00, 16'h1200);
		chk({15'h0, autoneg_restart}, 16'h0001);
		acc(0, 5'h00, 16'h0);
		chk(q, 16'h1100);
		$display("bits done");
	endtask
	task automatic t_srst;
		acc(1, 5'h00, 16'h8000);
		chk({14'h0, soft_reset, mgmt_ready}, 16'h0002);
		acc(0, 5'h00, 16'h0);
		chk(q, 16'h3180);
		#1 {strap_loopback, link_power_down} = 2'b11;
		@(posedge clk);
		#1 chk({14'h0, loopback_en, power_down}, 16'h0003);
		$display("reset done");
	endtask
	initial begin
		repeat (16) @(posedge clk);
		#1 nrst = 1;
		t_dflt;
		t_manual;
		t_bits;
		t_srst;
		conclude;
	end
endmodule // pbc_ctrl_reg_tb
